// [rtl/idt_core.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================
// decode and execution timing
module idt_core import idt_pkg::*; #(
  parameter int PW = 11
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic [PW-1:0] progAddr,
  input wire logic [IW-1:0] progWord,
  input wire logic [7:0] portPins,
  output logic [7:0] portLatch,
  output logic port_change_flag,
  output logic [7:0] accum,
  output logic [2:0] instrClass,
  output logic cycleEnd,
  output logic flushCycle
);
  // =====================================
  // decode functions
  function automatic idt_cls_t clsOf(input logic [IW-1:0] w);
    case (w[13:12])
      2'b00: clsOf = IDT_CLS_BYTE;
      2'b01: clsOf = IDT_CLS_BIT;
      default: clsOf = IDT_CLS_LIT;
    endcase
  endfunction

  function automatic idt_op_t opOf(input logic [IW-1:0] w);
    opOf = IDT_OP_NOP;
    case (w[13:12])
      2'b00: begin
        case (w[11:8])
          4'h0: begin
            if (w[7]) opOf = IDT_OP_MOVWF;
            else if (w[6:0] == 7'h08 || w[6:0] == 7'h09) opOf = IDT_OP_RET;
            else opOf = IDT_OP_NOP;
          end
          4'h1: opOf = IDT_OP_CLR;
          4'hB, 4'hF: opOf = IDT_OP_SKZ;
          default: opOf = IDT_OP_ALU;
        endcase
      end
      2'b01: opOf = w[11] ? IDT_OP_BTS : IDT_OP_BIT;
      2'b10: opOf = IDT_OP_JMP;
      default: begin
        // literal ops ignore low x bits
        case (w[11:9])
          3'b000, 3'b001, 3'b100, 3'b110, 3'b111: opOf = IDT_OP_LIT;
          // spare xor slot stays a nop
          3'b101: opOf = w[8] ? IDT_OP_NOP : IDT_OP_LIT;
          3'b010, 3'b011: opOf = IDT_OP_RET;
          default: opOf = IDT_OP_NOP;
        endcase
      end
    endcase
  endfunction

  // =====================================
  // phase counter
  logic [1:0] phase;
  logic [1:0] next_phase;
  always_comb begin
    next_phase = (phase == 2'(QUARTERS - 1)) ? 2'd0 : phase + 2'd1;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) phase <= 2'd0;
    else phase <= next_phase;
  end

  // =====================================
  // execution state
  logic [IW-1:0] ir;
  logic [PW-1:0] pc;
  logic flush;
  logic [7:0] w;
  logic [7:0] lat;
  logic [7:0] snap;
  logic chg;
  logic [IW-1:0] next_ir;
  logic [PW-1:0] next_pc;
  logic next_flush;
  logic [7:0] next_w;
  logic [7:0] next_lat;
  logic [7:0] next_snap;
  logic next_chg;
  logic [7:0] rfData;
  logic rfWe;
  logic [7:0] rfWdata;
  logic [FW-1:0] fAddr;
  logic [7:0] opnd;
  logic [7:0] res;
  logic [2:0] bpos;
  logic skip;
  logic isPort;
  idt_op_t op;

  assign fAddr = ir[FW-1:0];
  assign bpos = ir[9:7];
  assign isPort = (fAddr == PORT_ADDR);
  assign op = flush ? IDT_OP_NOP : opOf(ir);

  idt_regfile #(.AW(FW)) u_rf (
    .clock(clock),
    .readAddr(fAddr),
    .readData(rfData),
    .writeEn(rfWe),
    .writeAddr(fAddr),
    .writeData(rfWdata)
  );

  always_comb begin
    next_ir = ir;
    next_pc = pc;
    next_flush = flush;
    next_w = w;
    next_lat = lat;
    next_snap = snap;
    next_chg = chg | (portPins != snap);
    rfWe = 1'b0;
    rfWdata = 8'h00;
    skip = 1'b0;
    res = 8'h00;
    opnd = isPort ? portPins : rfData;
    if (phase == 2'(QUARTERS - 1)) begin
      case (op)
        IDT_OP_MOVWF: res = w;
        IDT_OP_CLR: res = 8'h00;
        IDT_OP_ALU: begin
          case (ir[11:8])
            4'h2: res = opnd - w;
            4'h3: res = opnd - 8'h01;
            4'h4: res = opnd | w;
            4'h5: res = opnd & w;
            4'h6: res = opnd ^ w;
            4'h7: res = opnd + w;
            4'h8: res = opnd;
            4'h9: res = ~opnd;
            4'hA: res = opnd + 8'h01;
            4'hC: res = {1'b0, opnd[7:1]};
            4'hD: res = {opnd[6:0], 1'b0};
            4'hE: res = {opnd[3:0], opnd[7:4]};
            default: res = opnd;
          endcase
        end
        IDT_OP_SKZ: begin
          res = ir[11:8] == 4'hB ? opnd - 8'h01 : opnd + 8'h01;
          skip = (res == 8'h00);
        end
        IDT_OP_BIT: begin
          res = opnd;
          res[bpos] = ir[10];
        end
        IDT_OP_BTS: skip = (opnd[bpos] == ir[10]);
        default: res = 8'h00;
      endcase
      case (op)
        IDT_OP_MOVWF, IDT_OP_CLR, IDT_OP_ALU, IDT_OP_SKZ, IDT_OP_BIT: begin
          if (op == IDT_OP_BIT || ir[7]) begin
            if (isPort) next_lat = res;
            else begin
              rfWe = 1'b1;
              rfWdata = res;
            end
          end else begin
            next_w = res;
          end
        end
        IDT_OP_LIT: begin
          case (ir[11:9])
            3'b000, 3'b001: next_w = ir[7:0];
            3'b100: next_w = ir[8] ? (w & ir[7:0]) : (w | ir[7:0]);
            3'b101: next_w = w ^ ir[7:0];
            3'b110: next_w = ir[7:0] - w;
            default: next_w = ir[7:0] + w;
          endcase
        end
        default: next_w = w;
      endcase
      if (op != IDT_OP_NOP && op != IDT_OP_LIT && op != IDT_OP_JMP &&
          op != IDT_OP_RET && isPort) begin
        next_snap = portPins;
        next_chg = 1'b0;
      end
      next_ir = progWord;
      next_pc = pc + PW'(1);
      next_flush = 1'b0;
      // skip or jump costs a nop cycle
      if (op == IDT_OP_JMP) begin
        next_pc = PW'(ir[KW-1:0]);
        next_flush = 1'b1;
      end else if (skip || op == IDT_OP_RET) begin
        next_flush = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ir <= NOP_WORD;
      pc <= PC_RESET;
      flush <= 1'b0;
      w <= W_RESET;
      lat <= 8'h00;
      snap <= 8'h00;
      chg <= 1'b0;
    end else begin
      ir <= next_ir;
      pc <= next_pc;
      flush <= next_flush;
      w <= next_w;
      lat <= next_lat;
      snap <= next_snap;
      chg <= next_chg;
    end
  end

  // =====================================
  // registered outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      progAddr <= PC_RESET;
      portLatch <= 8'h00;
      port_change_flag <= 1'b0;
      accum <= W_RESET;
      instrClass <= 3'b000;
      cycleEnd <= 1'b0;
      flushCycle <= 1'b0;
    end else begin
      progAddr <= next_pc;
      portLatch <= next_lat;
      port_change_flag <= next_chg;
      accum <= next_w;
      instrClass <= clsOf(ir);
      cycleEnd <= (phase == 2'(QUARTERS - 1));
      flushCycle <= flush;
    end
  end

  // =====================================
  // checks
  logic atCommit;
  assign atCommit = (phase == 2'(QUARTERS - 1));
  // after a pulse: three quiet clocks, then the next pulse
  sequence quietThenEnd;
    !cycleEnd [*3] ##1 cycleEnd;
  endsequence
  fourPhase_a: assert property (@(posedge clock) disable iff (!rst_n)
    cycleEnd |=> quietThenEnd) else $error("cycle not four clocks");
  jumpFlush_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && op == IDT_OP_JMP) |=> flush) else $error("jump without nop");
  skipFlush_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && skip) |=> flush) else $error("skip without nop");
  retFlush_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && op == IDT_OP_RET) |=> flush) else $error("return without nop");
  flushHold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && flush) |=> $stable(w)) else $error("nop changed w");
  nopHold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && op == IDT_OP_NOP) |=> ($stable(w) && $stable(lat)))
    else $error("nop changed state");
  portClr_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && op == IDT_OP_CLR && isPort) |=> !chg) else $error("flag kept");
  portBit_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && op == IDT_OP_BIT && isPort) |=> !chg) else $error("flag kept on bit op");
  destW_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && op == IDT_OP_ALU && !ir[7]) |=> $stable(lat)) else $error("bad dest");
  destF_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && op == IDT_OP_ALU && ir[7]) |=> $stable(w)) else $error("w hit on d one");
  litLoad_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && op == IDT_OP_LIT && ir[11:10] == 2'b00) |=> w == $past(ir[7:0]))
    else $error("literal not loaded");
  pcStep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!atCommit) |=> $stable(pc)) else $error("pc moved midcycle");
  // bit op on the port copies the other bits from portPins
  bitOnly_a: assert property (@(posedge clock) disable iff (!rst_n)
    (atCommit && op == IDT_OP_BIT && isPort) |=>
    (($countones(lat ^ $past(portPins))) <= 1)) else $error("extra bits changed");
endmodule
`default_nettype wire

// [rtl/idt_pkg.sv]
package idt_pkg;
  localparam int IW = 14;
  localparam int FW = 7;
  localparam int KW = 11;
  localparam int QUARTERS = 4;
  localparam logic [6:0] PORT_ADDR = 7'h06;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  typedef enum logic [3:0] {
    IDT_OP_NOP = 4'h0, IDT_OP_MOVWF = 4'h1, IDT_OP_CLR = 4'h2, IDT_OP_ALU = 4'h3,
    IDT_OP_SKZ = 4'h4, IDT_OP_BIT = 4'h5, IDT_OP_BTS = 4'h6, IDT_OP_LIT = 4'h7,
    IDT_OP_JMP = 4'h8, IDT_OP_RET = 4'h9
  } idt_op_t;
  typedef enum logic [2:0] {
    IDT_CLS_BYTE = 3'b001, IDT_CLS_BIT = 3'b010, IDT_CLS_LIT = 3'b100
  } idt_cls_t;
endpackage

// [rtl/idt_regfile.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================
// register file, registered read data
module idt_regfile #(
  parameter int AW = 7
) (
  input wire logic clock,
  input wire logic [AW-1:0] readAddr,
  output logic [7:0] readData,
  input wire logic writeEn,
  input wire logic [AW-1:0] writeAddr,
  input wire logic [7:0] writeData
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clock) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================
// self-checking bench for the decoder core
module tb import idt_pkg::*;;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [IW-1:0] progWord = NOP_WORD;
  logic [7:0] portPins = 8'h00;
  logic [10:0] progAddr;
  logic [7:0] portLatch;
  logic [7:0] accum;
  logic [2:0] instrClass;
  logic portChange;
  logic cycleEnd;
  logic flushCycle;
  logic [IW-1:0] rom [0:15];
  int mismatches = 0;
  int samplesChecked = 0;
  int flushSeen = 0;

  always #25 clock = ~clock;
  // program memory answers one small delay after each edge
  always @(posedge clock) #1 progWord = rom[progAddr[3:0]];

  idt_core DUT (
    .clock(clock),
    .rst_n(rst_n),
    .progAddr(progAddr),
    .progWord(progWord),
    .portPins(portPins),
    .portLatch(portLatch),
    .port_change_flag(portChange),
    .accum(accum),
    .instrClass(instrClass),
    .cycleEnd(cycleEnd),
    .flushCycle(flushCycle)
  );

  // =====================================
  // compares and closing
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic finalReport();
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // =====================================
  // helpers: reset with empty program, run n instruction cycles
  task automatic start();
    foreach (rom[i]) rom[i] = NOP_WORD;
    @(posedge clock);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
  endtask

  task automatic run(input int n);
    int gap = 0;
    int seen = 0;
    int guard = 0;
    // sample 2 ns after the edge so registered outputs have landed
    while (seen < n && guard < 400) begin
      @(posedge clock);
      #2;
      guard++;
      gap++;
      if (flushCycle === 1'b1) flushSeen++;
      if (cycleEnd === 1'b1) begin
        if (seen > 0) chk8(8'(gap), 8'h04);
        seen++;
        gap = 0;
      end
    end
    if (guard >= 400) begin
      mismatches++;
      $display("Error at %0t: no cycle end", $time);
    end
  endtask

  // =====================================
  // scenarios
  task automatic t_literal();
    start();
    rom[0] = 14'h335A;
    rom[1] = 14'h2801;
    run(5);
    chk8(accum, 8'h5A);
  endtask

  task automatic t_bytes();
    start();
    rom[0] = 14'h305A;
    rom[1] = 14'h00FF;
    rom[2] = 14'h077F;
    rom[3] = 14'h07FF;
    rom[4] = 14'h087F;
    rom[5] = 14'h2805;
    run(9);
    chk8(accum, 8'h0E);
  endtask

  task automatic t_class();
    logic [IW-1:0] words [3] = '{14'h00A0, 14'h1420, 14'h3011};
    logic [2:0] exps [3] = '{3'b001, 3'b010, 3'b100};
    for (int k = 0; k < 3; k++) begin
      start();
      foreach (rom[j]) rom[j] = words[k];
      run(4);
      chk8({5'h00, instrClass}, {5'h00, exps[k]});
    end
  endtask

  task automatic t_port();
    start();
    portPins = 8'h81;
    rom[0] = 14'h3000;
    rom[1] = 14'h0086;
    rom[2] = 14'h1586;
    rom[3] = 14'h2803;
    run(7);
    chk8(portLatch, 8'h89);
    chk1(portChange, 1'b0);
    @(posedge clock);
    #1 portPins = 8'h80;
    run(3);
    chk1(portChange, 1'b1);
    rom[3] = 14'h0186;
    rom[4] = 14'h2804;
    run(6);
    chk1(portChange, 1'b0);
    chk8(portLatch, 8'h00);
  endtask

  task automatic t_flow();
    start();
    rom[0] = 14'h3001;
    rom[1] = 14'h00A0;
    rom[2] = 14'h1C20;
    rom[3] = 14'h30FF;
    rom[4] = 14'h0001;
    rom[5] = 14'h2807;
    rom[6] = 14'h30EE;
    rom[7] = 14'h2807;
    flushSeen = 0;
    run(12);
    chk8(accum, 8'h01);
    chk1(flushSeen != 0, 1'b1);
  endtask

  task automatic t_ops();
    start();
    rom[0] = 14'h30F0;
    rom[1] = 14'h380F;
    rom[2] = 14'h393C;
    rom[3] = 14'h3AFF;
    rom[4] = 14'h3C05;
    rom[5] = 14'h3F10;
    rom[6] = 14'h00A1;
    rom[7] = 14'h0EA1;
    rom[8] = 14'h0B21;
    rom[9] = 14'h0008;
    rom[10] = 14'h30AA;
    rom[11] = 14'h280B;
    run(16);
    chk8(accum, 8'h24);
  endtask

  initial begin
    t_literal();
    t_bytes();
    t_class();
    t_port();
    t_flow();
    t_ops();
    finalReport();
  end

  // watchdog: the whole run needs well under 1000 clocks
  initial begin
    #200000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    finalReport();
  end
endmodule
`default_nettype wire
